//--- ist_pkg.sv
// constants and carrier types for the iron safety timeout block
// assumes a single 50 MHz core clock and synchronous pin inputs
package ist_pkg;

    // core clock
    localparam int unsigned CLK_HZ          = 50_000_000;

    // mains time base, default variant and timeouts
    localparam int unsigned MAINS_HZ_DEF    = 60;
    localparam int unsigned HORIZ_TIMEOUT_S = 30;
    localparam int unsigned VERT_TIMEOUT_MIN = 8;
    localparam int unsigned VERT_TIMEOUT_S  = VERT_TIMEOUT_MIN * 60;
    localparam int unsigned TICK_W          = 15;

    // indicator flash rate, half period rounded down
    localparam int unsigned FLASH_HZ        = 4;
    localparam int unsigned FLASH_HALF_CYC  = CLK_HZ / (2 * FLASH_HZ);
    localparam int unsigned FLASH_W         = 23;

    // sensor debounce, least time rounded down
    localparam int unsigned DEBOUNCE_MS     = 10;
    localparam int unsigned DEBOUNCE_CYC    = (CLK_HZ / 1000) * DEBOUNCE_MS;

    // mains input hysteresis in time, least time rounded down
    localparam int unsigned MAINS_FILT_US   = 500;
    localparam int unsigned MAINS_FILT_CYC  = (CLK_HZ / 1_000_000) * MAINS_FILT_US;

    // reset levels of the conditioned inputs
    localparam logic        SENSOR_RST_LVL  = 1'b1;
    localparam logic        MAINS_RST_LVL   = 1'b0;

    typedef enum logic [0:0] {
        ST_HEAT = 1'b0,
        ST_OFF  = 1'b1
    } ist_state_t;

    typedef struct packed {
        logic horiz;
        logic moved;
        logic mains_tick;
    } ist_sense_t;

endpackage

//--- ist_filter.sv
// time-hysteresis filter: output follows input only after LEN stable cycles
// assumes raw_i is already synchronous to clk_i
module ist_filter #(
    parameter int unsigned LEN     = 4,
    parameter logic        RST_VAL = 1'b0
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic nrst_i,
    // raw and filtered level
    input  wire logic raw_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      change_o
);

    localparam int unsigned W = $clog2(LEN + 1);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         level_q;
    logic         differ_w;
    logic         flip_w;

    assign differ_w = raw_i != level_q;
    assign flip_w   = differ_w && (cnt_q == W'(LEN - 1));
    assign cnt_d    = (!differ_w || flip_w) ? '0 : cnt_q + W'(1);

    // short glitches restart the count, so bounce never reaches the output
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q   <= '0;
            level_q <= RST_VAL;
        end else begin
            cnt_q   <= cnt_d;
            level_q <= flip_w ? raw_i : level_q;
        end
    end

    assign level_o  = level_q;
    assign rise_o   = flip_w && raw_i;
    assign change_o = flip_w;

endmodule

//--- ist_iron_ctrl.sv
// iron automatic shut-off: position timeout, relay drive and indicator flash
// assumes pads supply pull-ups on sensor and mode pins, inputs synchronous
// to core_clk_i, and a power-on reset on nrst_i

////////////////////////////////////////////////////////////////////////////////

// Overview of operation
// - relay high while heating, low when stopped
// - horizontal and still over 30 s stops heating
// - vertical and still over 8 min stops heating
// - timeouts count 60 Hz or 50 Hz mains cycles
// - after timeout indicator pulses at about 4 Hz
// - indicator released while heating, LED stays lit
// - mode pin high normal, low quick test
// - sensor pin gives position and movement
// - mains input conditioned by hysteresis before counting
module ist_iron_ctrl #(
    parameter int unsigned MAINS_HZ       = ist_pkg::MAINS_HZ_DEF,
    parameter int unsigned FLASH_HALF_CYC = ist_pkg::FLASH_HALF_CYC,
    parameter int unsigned DEBOUNCE_CYC   = ist_pkg::DEBOUNCE_CYC,
    parameter int unsigned MAINS_FILT_CYC = ist_pkg::MAINS_FILT_CYC
) (
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic nrst_i,
    // sensor, mains and mode pins
    input  wire logic mains_clock_in_i,
    input  wire logic sensor_in_i,
    input  wire logic test_mode_n_i,
    // relay drive
    output logic      relay_drive_out_o,
    // open-drain indicator
    input  wire logic led_in_i,
    output logic      led_o,
    output logic      led_oe_n_o
);

    ////////////////////////////////////////////////////////////////////////////

    ist_pkg::ist_state_t         state_q;
    ist_pkg::ist_state_t         state_d;
    ist_pkg::ist_sense_t         sense_w;
    logic [ist_pkg::TICK_W-1:0]  tick_cnt_q;
    logic [ist_pkg::TICK_W-1:0]  tick_cnt_d;
    logic [ist_pkg::TICK_W-1:0]  lim_w;
    logic [ist_pkg::TICK_W-1:0]  lim_h_w;
    logic [ist_pkg::TICK_W-1:0]  lim_v_w;
    logic [ist_pkg::FLASH_W-1:0] flash_q;
    logic [ist_pkg::FLASH_W-1:0] flash_d;
    logic                        flash_wrap_w;
    logic                        led_pull_q;
    logic                        led_pull_d;
    logic                        expire_w;
    logic                        sensor_lvl_w;
    logic                        sensor_chg_w;
    logic                        mains_rise_w;
    logic                        test_w;

    ////////////////////////////////////////////////////////////////////////////
    // input conditioning

    // mains edges only count once stable, so slow noisy crossings give one tick
    ist_filter #(
        .LEN     (MAINS_FILT_CYC),
        .RST_VAL (ist_pkg::MAINS_RST_LVL)
    ) u_mains_filt (
        .clk_i    (core_clk_i),
        .nrst_i   (nrst_i),
        .raw_i    (mains_clock_in_i),
        .level_o  (),
        .rise_o   (mains_rise_w),
        .change_o ()
    );

    ist_filter #(
        .LEN     (DEBOUNCE_CYC),
        .RST_VAL (ist_pkg::SENSOR_RST_LVL)
    ) u_sensor_filt (
        .clk_i    (core_clk_i),
        .nrst_i   (nrst_i),
        .raw_i    (sensor_in_i),
        .level_o  (sensor_lvl_w),
        .rise_o   (),
        .change_o (sensor_chg_w)
    );

    // open (pulled-up) switch reads horizontal; any clean edge is movement
    // single driver for the carrier; per-field assigns risk multiple drivers
    assign sense_w = '{
        horiz:      sensor_lvl_w,
        moved:      sensor_chg_w,
        mains_tick: mains_rise_w
    };

    ////////////////////////////////////////////////////////////////////////////
    // timeout selection

    // pulled-up pin: floating means normal; test mode counts each mains tick as one second
    assign test_w  = !test_mode_n_i;
    assign lim_h_w = test_w ? ist_pkg::TICK_W'(ist_pkg::HORIZ_TIMEOUT_S)
                            : ist_pkg::TICK_W'(ist_pkg::HORIZ_TIMEOUT_S * MAINS_HZ);
    assign lim_v_w = test_w ? ist_pkg::TICK_W'(ist_pkg::VERT_TIMEOUT_S)
                            : ist_pkg::TICK_W'(ist_pkg::VERT_TIMEOUT_S * MAINS_HZ);
    assign lim_w   = sense_w.horiz ? lim_h_w : lim_v_w;

    assign expire_w = (state_q == ist_pkg::ST_HEAT) && !sense_w.moved
                      && sense_w.mains_tick
                      && (tick_cnt_q >= lim_w - ist_pkg::TICK_W'(1));

    ////////////////////////////////////////////////////////////////////////////
    // state and counters

    assign state_d = sense_w.moved ? ist_pkg::ST_HEAT
                   : expire_w      ? ist_pkg::ST_OFF
                   : state_q;

    // counter holds once stopped; a movement always clears it
    assign tick_cnt_d = sense_w.moved ? '0
                      : (state_q == ist_pkg::ST_HEAT && sense_w.mains_tick && !expire_w)
                        ? tick_cnt_q + ist_pkg::TICK_W'(1)
                      : tick_cnt_q;

    assign flash_wrap_w = flash_q == ist_pkg::FLASH_W'(FLASH_HALF_CYC - 1);
    assign flash_d      = (state_q != ist_pkg::ST_OFF || flash_wrap_w)
                          ? '0 : flash_q + ist_pkg::FLASH_W'(1);
    assign led_pull_d   = (state_d != ist_pkg::ST_OFF) ? 1'b0
                        : flash_wrap_w ? !led_pull_q : led_pull_q;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q    <= ist_pkg::ST_HEAT;
            tick_cnt_q <= '0;
            flash_q    <= '0;
            led_pull_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            tick_cnt_q <= tick_cnt_d;
            flash_q    <= flash_d;
            led_pull_q <= led_pull_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drive

    assign relay_drive_out_o = state_q == ist_pkg::ST_HEAT;
    // open drain: only ever pulls low; released means LED lit
    assign led_o      = 1'b0;
    assign led_oe_n_o = !led_pull_q;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_still_tick;
        (state_q == ist_pkg::ST_HEAT) && !sense_w.moved && sense_w.mains_tick;
    endsequence

    sequence s_last_tick;
        s_still_tick ##0 (tick_cnt_q == lim_w - ist_pkg::TICK_W'(1));
    endsequence

    a_relay_led_link: assert property (relay_drive_out_o |-> led_oe_n_o)
        else $error("indicator pulled while heating");

    a_horiz_timeout: assert property (s_last_tick ##0 sense_w.horiz |=> !relay_drive_out_o)
        else $error("horizontal timeout missed");

    a_vert_timeout: assert property (s_last_tick ##0 !sense_w.horiz |=> !relay_drive_out_o)
        else $error("vertical timeout missed");

    a_no_early_stop: assert property ($fell(relay_drive_out_o) |->
            $past(sense_w.mains_tick) && ($past(tick_cnt_q) >= $past(lim_w) - ist_pkg::TICK_W'(1)))
        else $error("relay dropped before count reached");

    a_flash_toggle: assert property ((state_q == ist_pkg::ST_OFF) && flash_wrap_w && !sense_w.moved
            |=> $changed(led_oe_n_o))
        else $error("indicator did not toggle at half period");

    a_flash_steady: assert property ((state_q == ist_pkg::ST_OFF) && !flash_wrap_w && !sense_w.moved
            |=> $stable(led_oe_n_o))
        else $error("indicator toggled off schedule");

    a_test_limit: assert property (!test_mode_n_i && sense_w.horiz
            |-> lim_w == ist_pkg::TICK_W'(ist_pkg::HORIZ_TIMEOUT_S))
        else $error("test mode limit wrong");

    a_count_on_tick: assert property ((state_q == ist_pkg::ST_HEAT) && !sense_w.moved
            && !sense_w.mains_tick |=> $stable(tick_cnt_q))
        else $error("count moved without mains edge");

    a_move_restart: assert property (sense_w.moved |=> relay_drive_out_o && tick_cnt_q == '0)
        else $error("movement did not restart heating");

    a_off_holds: assert property ((state_q == ist_pkg::ST_OFF) && !sense_w.moved
            |=> !relay_drive_out_o)
        else $error("heating resumed without movement");

    a_norm_h_limit: assert property (test_mode_n_i && sense_w.horiz
            |-> lim_w == ist_pkg::TICK_W'(ist_pkg::HORIZ_TIMEOUT_S * MAINS_HZ))
        else $error("horizontal mains limit wrong");

    a_norm_v_limit: assert property (test_mode_n_i && !sense_w.horiz
            |-> lim_w == ist_pkg::TICK_W'(ist_pkg::VERT_TIMEOUT_S * MAINS_HZ))
        else $error("vertical mains limit wrong");

    a_test_v_limit: assert property (!test_mode_n_i && !sense_w.horiz
            |-> lim_w == ist_pkg::TICK_W'(ist_pkg::VERT_TIMEOUT_S))
        else $error("test mode vertical limit wrong");

    a_tick_advance: assert property ((state_q == ist_pkg::ST_HEAT)
            && sense_w.mains_tick && !sense_w.moved && !expire_w
            |=> tick_cnt_q == $past(tick_cnt_q) + ist_pkg::TICK_W'(1))
        else $error("count did not advance on mains edge");

    a_off_count_hold: assert property ((state_q == ist_pkg::ST_OFF)
            && !sense_w.moved |=> $stable(tick_cnt_q))
        else $error("count moved while stopped");

    a_wake_release: assert property (sense_w.moved |=> led_oe_n_o)
        else $error("indicator still pulled after movement");

    a_stop_led_lit: assert property ($fell(relay_drive_out_o) |-> led_oe_n_o)
        else $error("indicator pulled at once on stop");

endmodule

//--- ist_partner.sv
// far-side model: tilt switch, mains square wave, mode strap and led wire
// assumes the bench sets wanted switch level and strap just after an edge
module ist_partner #(
    parameter int HALF = 8
) (
    // clock
    input  wire logic clk_i,
    // bench requests
    input  wire logic tilt_i,
    input  wire logic mode_low_i,
    // dut led pin
    input  wire logic led_i,
    input  wire logic led_oe_n_i,
    // pins towards the dut
    output logic      mains_o,
    output logic      sensor_o,
    output logic      mode_n_o,
    output wire       led_pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial mains_o = 1'b0;
    // mains runs free, never stops between timeouts
    always @(posedge clk_i) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) mains_o <= #1 ~mains_o;
    end
    assign sensor_o = tilt_i;
    assign mode_n_o = mode_low_i ? 1'b0 : 1'b1;
    // led pulls the pin up while released
    assign led_pin_o = led_oe_n_i ? 1'b1 : led_i;
endmodule

//--- tb_iron_safety_timeout_control.sv
// self-checking bench for the iron shut-off block
// assumes shortened filter, debounce, flash and mains-rate parameters
module tb_iron_safety_timeout_control;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MH = 2;
    localparam int FC = 2;
    localparam int DB = 4;
    localparam int FH = 8;
    logic core_clk_i = 1'b0;
    logic nrst_i     = 1'b0;
    logic tilt       = 1'b1;
    logic mode_low   = 1'b0;
    logic mains, sensor, mode_n, relay, led, led_oe_n;
    wire  led_pin;
    int   errors     = 0;
    int   n_checks   = 0;

    ist_iron_ctrl #(.MAINS_HZ(MH), .FLASH_HALF_CYC(FH), .DEBOUNCE_CYC(DB),
        .MAINS_FILT_CYC(FC)) i_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .mains_clock_in_i(mains), .sensor_in_i(sensor), .test_mode_n_i(mode_n),
        .relay_drive_out_o(relay), .led_in_i(led_pin), .led_o(led),
        .led_oe_n_o(led_oe_n));
    ist_partner #(.HALF(8)) i_partner (.clk_i(core_clk_i), .tilt_i(tilt),
        .mode_low_i(mode_low), .led_i(led), .led_oe_n_i(led_oe_n),
        .mains_o(mains), .sensor_o(sensor), .mode_n_o(mode_n), .led_pin_o(led_pin));

    ////////////////////////////////////////////////////////////////////////
    initial forever #10 core_clk_i = ~core_clk_i;

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic got, input logic exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    task automatic rises(input int n);
        repeat (n) begin
            while (mains !== 1'b0) cyc(1);
            while (mains !== 1'b1) cyc(1);
        end
    endtask

    // moves start at a mains fall so no tick straddles the restart
    task automatic move_to(input logic v);
        rises(1);
        while (mains !== 1'b0) cyc(1);
        tilt = v;
        cyc(DB + 2);
        chk(relay, 1'b1, "relay after movement");
        chk(led_oe_n, 1'b1, "led released while heating");
    endtask

    task automatic expire(input logic h, input logic tm);
        int lim;
        int k;
        lim = (h ? 30 : 480) * (tm ? 1 : MH);
        mode_low = tm;
        // a stopped iron already lying at h needs one real edge to wake
        if (tilt === h) move_to(~h);
        move_to(h);
        rises($urandom_range(lim - 2, 0));
        move_to(~h);
        move_to(h);
        rises(lim - 1);
        cyc(FC + 3);
        chk(relay, 1'b1, "relay dropped early");
        rises(1);
        k = 0;
        while (relay !== 1'b0 && k < FC + 4) begin
            cyc(1);
            k++;
        end
        chk(relay, 1'b0, "relay held at limit");
        chk(led, 1'b0, "led data not low");
        for (k = 1; k < 3 * FH; k++) begin
            cyc(1);
            chk(led_oe_n, (k / FH) % 2 == 0, "flash phase");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int r;
        r = $urandom(32'hC830BB85);
        cyc(12);
        chk(relay, 1'b1, "relay in reset");
        chk(led_oe_n, 1'b1, "led in reset");
        nrst_i = 1'b1;
        cyc(1);
        chk(relay, 1'b1, "relay after reset");
        expire(1'b1, 1'b0);
        // bounce shorter than debounce must not wake the iron
        r = $urandom_range(DB - 1, 1);
        tilt = ~tilt;
        cyc(r);
        tilt = ~tilt;
        cyc(DB + 2);
        chk(relay, 1'b0, "bounce woke relay");
        expire(1'b0, 1'b0);
        expire(1'b1, 1'b1);
        expire(1'b0, 1'b1);
        nrst_i = 1'b0;
        #1;
        chk(relay, 1'b1, "relay in mid-run reset");
        cyc(2);
        nrst_i = 1'b1;
        cyc(2);
        chk(led_oe_n, 1'b1, "led after mid-run reset");
        finish_test();
    end

    // run needs at most about 50000 cycles
    initial begin
        #(70000 * 20);
        errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule
